//--- design/scg_pkg.sv
// package of offsets, fields, reset values and carrier types for the system clock generator
// Summary of operation
// - enable high-speed oscillator, wait stable flag
// - boot runs from internal oscillator
// - system clock from source and divider
// - key 0x0096 unlocks protected writes
// - sleep stops sources with sleep-stop set
// - wake switch loads wake source, divider
// - sleep gates real-time clock input
// - output pin drives selected divided clock
// - trim start self-clears, sets done flag
// - trimming lasts about ten milliseconds
// - halt stops CPU, clocks keep running
// - interrupt, NMI, debug, reset end halt/sleep
// - three sticky flags, cleared writing one
// - interrupt only when flag and enable
// - reset release enters run mode
// - debug interrupt enters debug, return exits
// - wake fields at 15, 13-12, 9-8
// - source and divider code meanings
// - selecting stopped source starts it
// - wake switch clears enables of sleep-stopped sources other than the wake source
package scg_pkg;
  localparam logic [7:0] OFS_PROTECT = 8'h00;
  localparam logic [7:0] OFS_SYSTEM_CLOCK = 8'h04;
  localparam logic [7:0] OFS_OSCCTL = 8'h08;
  localparam logic [7:0] OFS_TRIM = 8'h0C;
  localparam logic [7:0] OFS_INTFLAG = 8'h10;
  localparam logic [7:0] OFS_INTEN = 8'h14;
  localparam logic [7:0] OFS_FOUT = 8'h18;
  localparam logic [7:0] OFS_HSADJ = 8'h1C;
  localparam logic [7:0] OFS_HSWAIT = 8'h20;
  localparam logic [7:0] OFS_MODE = 8'h24;
  localparam logic [15:0] PROTECT_KEY = 16'h0096;
  // system clock select fields
  localparam int SRC_LSB = 0;
  localparam int DIV_LSB = 4;
  localparam int WSRC_LSB = 8;
  localparam int WDIV_LSB = 12;
  localparam int WEN_BIT = 15;
  // oscillator control fields: enables at 3..0, sleep stops at 11..8
  localparam int EN_LSB = 0;
  localparam int SLPC_LSB = 8;
  localparam int TRIM_BIT = 4;
  // flag and enable positions
  localparam int F_INT = 0;
  localparam int F_HS = 2;
  localparam int F_TRIM = 4;
  // clock output fields
  localparam int FOEN_BIT = 0;
  localparam int FOSRC_LSB = 2;
  localparam int FODIV_LSB = 4;
  // source codes
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_LOWPOWER = 2'h1;
  localparam logic [1:0] SRC_HIGHSPEED = 2'h2;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;
  // reset values
  localparam logic [3:0] RST_ENABLES = 4'h1;
  localparam logic [3:0] RST_SLEEPSTOP = 4'hF;
  localparam logic [2:0] RST_HSWAIT = 3'h6;
  localparam logic [5:0] RST_HSADJ = 6'h00;
  // timing: internal settles in 16 of its clocks, counted as half periods
  localparam logic [17:0] INT_SETTLE_HALVES = 18'h00020;
  localparam int TRIM_TIME_US = 10000;
  localparam int REF_FREQ_HZ = 32768;
  localparam int TRIM_REF_EDGES = (TRIM_TIME_US * REF_FREQ_HZ) / 1000000;

  typedef enum {MODE_RUN, MODE_HALT, MODE_SLEEP, MODE_DEBUG} scg_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } scg_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } scg_apb_rsp_t;

  typedef struct packed {
    logic haltExec;
    logic sleepExec;
    logic retdExec;
    logic periphIrq;
    logic wdtNmi;
    logic debugIrq;
    logic resetReq;
  } scg_cpu_evt_t;
endpackage

//--- design/scg_clk_div.sv
// power-of-two clock divider with low-phase source switching
`timescale 1ns/1ps
module scg_clk_div (
  input wire logic clk, // block clock
  input wire logic resetn, // async reset, active low
  input wire logic [3:0] srcLevel, // synchronised source levels
  input wire logic [1:0] sel, // requested source
  input wire logic [3:0] divExp, // requested divide exponent
  input wire logic en, // output allowed
  output logic clkOut // divided clock
);
  logic [1:0] curSel_r;
  logic [3:0] curExp_r;
  logic prevLvl_r;
  logic [14:0] cnt_r;
  logic [14:0] limit;
  logic edgeSeen;
  logic swap;
  assign limit = 15'((32'h1 << curExp_r) - 32'h1);
  assign edgeSeen = srcLevel[curSel_r] != prevLvl_r;
  // a change only lands while the output is low, so no pulse is cut short
  assign swap = !clkOut && ((sel != curSel_r) || (divExp != curExp_r));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      curSel_r <= 2'h0;
      curExp_r <= 4'h0;
      prevLvl_r <= 1'b0;
      cnt_r <= 15'h0000;
      clkOut <= 1'b0;
    end else if (swap) begin
      curSel_r <= sel;
      curExp_r <= divExp;
      prevLvl_r <= srcLevel[sel];
      cnt_r <= 15'h0000;
    end else if (!en) begin
      clkOut <= 1'b0;
      cnt_r <= 15'h0000;
      prevLvl_r <= srcLevel[curSel_r];
    end else if (edgeSeen) begin
      prevLvl_r <= srcLevel[curSel_r];
      if (cnt_r == limit) begin
        cnt_r <= 15'h0000;
        clkOut <= !clkOut;
      end else begin
        cnt_r <= cnt_r + 15'h0001;
      end
    end
  end
endmodule

//--- design/scg_clock_gen.sv
// system clock generator: sources, dividers, sleep control, trimming, flags, apb registers
`timescale 1ns/1ps
module scg_clock_gen #(
  parameter int TRIM_EDGES = scg_pkg::TRIM_REF_EDGES
) (
  input wire logic clk, // 40 MHz block clock
  input wire logic resetn, // async reset, active low
  input wire scg_pkg::scg_apb_req_t apbReq, // apb request
  output scg_pkg::scg_apb_rsp_t apbRsp, // apb response
  input wire logic [3:0] oscClockPins, // ext, high-speed, low-power, internal clocks
  input wire scg_pkg::scg_cpu_evt_t cpuEvt, // cpu instruction and wake events
  output logic [3:0] sourceRun, // run request per source
  output logic rtcLowpowerInput, // gate of the real-time clock input
  output logic systemClock, // divided system clock
  output logic clockOutputPin, // clock output pin level
  output logic [5:0] highspeedFineAdjust, // fine adjust to oscillator
  output logic [2:0] highspeedSettleTime, // settle code to oscillator
  output logic trimActive, // trimming engine running
  output logic clkIrq, // interrupt request to controller
  output logic cpuStop, // cpu held (halt, sleep)
  output logic [1:0] cpuMode // 0 run, 1 halt, 2 sleep, 3 debug
);
  import scg_pkg::*;

  // pin clocks pass two flops before use
  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;
  logic [3:0] pinPrev_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_r <= 4'h0;
      pinSync_r <= 4'h0;
      pinPrev_r <= 4'h0;
    end else begin
      pinMeta_r <= oscClockPins;
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end
  logic [3:0] srcEdge;
  assign srcEdge = pinSync_r ^ pinPrev_r;

  // register state
  logic unlocked_r;
  logic [1:0] sysSrc_r, sysDiv_r, wakeSrc_r, wakeDiv_r;
  logic wakeEn_r;
  logic [3:0] srcEn_r, sleepStop_r;
  logic trimStart_r;
  logic [2:0] flags_r, irqEn_r;
  logic output_enable_r;
  logic [1:0] output_source_sel_r;
  logic [2:0] output_divider_sel_r;
  logic [5:0] hsAdj_r;
  logic [2:0] hsWait_r;
  scg_mode_t mode_r, mode_nxt;

  // apb decode
  logic setupPh, accessPh, wrCommit;
  logic [31:0] wd;
  assign setupPh = apbReq.psel && !apbReq.penable;
  assign accessPh = apbReq.psel && apbReq.penable;
  assign wrCommit = accessPh && apbRsp.pready && apbReq.pwrite && !apbRsp.pslverr;
  assign wd = apbReq.pwdata;
  wire wrProt = wrCommit && apbReq.paddr == OFS_PROTECT;
  wire wrSys = wrCommit && apbReq.paddr == OFS_SYSTEM_CLOCK && unlocked_r;
  wire wrOsc = wrCommit && apbReq.paddr == OFS_OSCCTL;
  wire wrTrim = wrCommit && apbReq.paddr == OFS_TRIM && unlocked_r;
  wire wrFlag = wrCommit && apbReq.paddr == OFS_INTFLAG;
  wire wrIen = wrCommit && apbReq.paddr == OFS_INTEN;
  wire wrFout = wrCommit && apbReq.paddr == OFS_FOUT;
  wire wrAdj = wrCommit && apbReq.paddr == OFS_HSADJ && unlocked_r;
  wire wrWait = wrCommit && apbReq.paddr == OFS_HSWAIT && unlocked_r;

  // operating modes
  wire wakeCause = cpuEvt.periphIrq || cpuEvt.wdtNmi || cpuEvt.debugIrq || cpuEvt.resetReq;
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_RUN: begin
        if (cpuEvt.debugIrq) begin
          mode_nxt = MODE_DEBUG;
        end else if (cpuEvt.haltExec) begin
          mode_nxt = MODE_HALT;
        end else if (cpuEvt.sleepExec) begin
          mode_nxt = MODE_SLEEP;
        end
      end
      MODE_HALT, MODE_SLEEP: begin
        // taken whether or not the cpu then accepts the interrupt
        if (cpuEvt.debugIrq) begin
          mode_nxt = MODE_DEBUG;
        end else if (wakeCause) begin
          mode_nxt = MODE_RUN;
        end
      end
      MODE_DEBUG: begin
        if (cpuEvt.retdExec) begin
          mode_nxt = MODE_RUN;
        end
      end
      default: mode_nxt = MODE_RUN;
    endcase
  end
  wire inSleep = mode_r == MODE_SLEEP;
  wire leaveSleep = inSleep && mode_nxt != MODE_SLEEP;
  wire wakeSwitch = leaveSleep && wakeEn_r;

  // source run requests: sleep stops only the marked sources
  logic [3:0] runNow;
  assign runNow = srcEn_r & ~({4{inSleep}} & sleepStop_r);

  // stabilisation counters, counted in source half periods
  logic [17:0] intCnt_r, hsCnt_r;
  logic intStable_r, hsStable_r;
  logic [17:0] hsTarget;
  assign hsTarget = 18'(32'h8 << (2 * hsWait_r));
  wire intDone = runNow[SRC_INTERNAL] && !intStable_r && srcEdge[SRC_INTERNAL] &&
    intCnt_r == INT_SETTLE_HALVES - 18'h1;
  wire hsDone = runNow[SRC_HIGHSPEED] && !hsStable_r && srcEdge[SRC_HIGHSPEED] &&
    hsCnt_r == hsTarget - 18'h1;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      intCnt_r <= 18'h00000;
      hsCnt_r <= 18'h00000;
      intStable_r <= 1'b1; // already settled when reset lifts, flag stays clear
      hsStable_r <= 1'b0;
    end else begin
      if (!runNow[SRC_INTERNAL]) begin
        intCnt_r <= 18'h00000;
        intStable_r <= 1'b0;
      end else if (intDone) begin
        intStable_r <= 1'b1;
      end else if (!intStable_r && srcEdge[SRC_INTERNAL]) begin
        intCnt_r <= intCnt_r + 18'h00001;
      end
      if (!runNow[SRC_HIGHSPEED]) begin
        hsCnt_r <= 18'h00000;
        hsStable_r <= 1'b0;
      end else if (hsDone) begin
        hsStable_r <= 1'b1;
      end else if (!hsStable_r && srcEdge[SRC_HIGHSPEED]) begin
        hsCnt_r <= hsCnt_r + 18'h00001;
      end
    end
  end
  logic [3:0] srcReady;
  assign srcReady = {runNow[SRC_EXTERNAL], hsStable_r, runNow[SRC_LOWPOWER], intStable_r};

  // auto trimming against the low-power reference; long by nature, so the count is a parameter
  logic [15:0] trimCnt_r;
  wire trimDone = trimStart_r && runNow[SRC_LOWPOWER] && srcEdge[SRC_LOWPOWER] &&
    trimCnt_r == 16'(2 * TRIM_EDGES - 1);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trimCnt_r <= 16'h0000;
    end else if (!trimStart_r || trimDone) begin
      trimCnt_r <= 16'h0000;
    end else if (runNow[SRC_LOWPOWER] && srcEdge[SRC_LOWPOWER]) begin
      trimCnt_r <= trimCnt_r + 16'h0001;
    end
  end

  // protection key and protected fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unlocked_r <= 1'b0;
      sysSrc_r <= SRC_INTERNAL;
      sysDiv_r <= 2'h0;
      wakeSrc_r <= 2'h0;
      wakeDiv_r <= 2'h0;
      wakeEn_r <= 1'b0;
      hsAdj_r <= RST_HSADJ;
      hsWait_r <= RST_HSWAIT;
    end else begin
      if (wrProt) begin
        unlocked_r <= wd[15:0] == PROTECT_KEY;
      end
      if (wakeSwitch) begin
        sysSrc_r <= wakeSrc_r;
        sysDiv_r <= wakeDiv_r;
      end else if (wrSys) begin
        sysSrc_r <= wd[SRC_LSB +: 2];
        sysDiv_r <= wd[DIV_LSB +: 2];
        wakeSrc_r <= wd[WSRC_LSB +: 2];
        wakeDiv_r <= wd[WDIV_LSB +: 2];
        wakeEn_r <= wd[WEN_BIT];
      end
      // the oscillator only reads the adjust while halted; software keeps to that
      if (wrAdj) begin
        hsAdj_r <= wd[5:0];
      end
      if (wrWait) begin
        hsWait_r <= wd[2:0];
      end
    end
  end

  // source enables: wake clean-up, software writes, then automatic start
  logic [3:0] enKeep, enBase, enAuto;
  assign enKeep = (4'h1 << wakeSrc_r) | ~sleepStop_r;
  assign enBase = wakeSwitch ? (srcEn_r & enKeep) : (wrOsc ? wd[EN_LSB +: 4] : srcEn_r);
  assign enAuto = wakeSwitch ? (4'h1 << wakeSrc_r) : (wrSys ? (4'h1 << wd[SRC_LSB +: 2]) : 4'h0);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srcEn_r <= RST_ENABLES;
      sleepStop_r <= RST_SLEEPSTOP;
    end else begin
      srcEn_r <= enBase | enAuto;
      if (wrOsc) begin
        sleepStop_r <= wd[SLPC_LSB +: 4];
      end
    end
  end

  // trim start, flags, interrupt enables, clock output control
  logic [2:0] flagSet, flagClr;
  assign flagSet = {trimDone, hsDone, intDone};
  assign flagClr = wrFlag ? {wd[F_TRIM], wd[F_HS], wd[F_INT]} : 3'h0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trimStart_r <= 1'b0;
      flags_r <= 3'h0;
      irqEn_r <= 3'h0;
      output_enable_r <= 1'b0;
      output_source_sel_r <= 2'h0;
      output_divider_sel_r <= 3'h0;
    end else begin
      if (trimDone) begin
        trimStart_r <= 1'b0;
      end else if (wrTrim) begin
        trimStart_r <= wd[TRIM_BIT];
      end
      flags_r <= flagSet | (flags_r & ~flagClr);
      if (wrIen) begin
        irqEn_r <= {wd[F_TRIM], wd[F_HS], wd[F_INT]};
      end
      if (wrFout) begin
        output_enable_r <= wd[FOEN_BIT];
        output_source_sel_r <= wd[FOSRC_LSB +: 2];
        output_divider_sel_r <= wd[FODIV_LSB +: 3];
      end
    end
  end

  // active system selection follows the request once that source is ready
  logic [1:0] actSrc_r, actDiv_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      actSrc_r <= SRC_INTERNAL;
      actDiv_r <= 2'h0;
    end else if (srcReady[sysSrc_r]) begin
      actSrc_r <= sysSrc_r;
      actDiv_r <= sysDiv_r;
    end
  end

  function automatic logic [3:0] outExp(input logic [1:0] src, input logic [2:0] code);
    logic [3:0] e;
    e = {1'b0, code};
    if (src == SRC_LOWPOWER) begin
      if (code == 3'h7) begin
        e = 4'hF;
      end else if (code == 3'h6) begin
        e = 4'hC;
      end else if (code == 3'h5) begin
        e = 4'hA;
      end
    end
    return e;
  endfunction

  logic sysClkInt, foutInt;
  scg_clk_div sysDivider (
    .clk(clk),
    .resetn(resetn),
    .srcLevel(pinSync_r),
    .sel(actSrc_r),
    .divExp({2'b00, actDiv_r}),
    .en(1'b1),
    .clkOut(sysClkInt)
  );
  // source 3 of the output mux is the system clock itself
  scg_clk_div outDivider (
    .clk(clk),
    .resetn(resetn),
    .srcLevel({sysClkInt, pinSync_r[2:0]}),
    .sel(output_source_sel_r),
    .divExp(outExp(output_source_sel_r, output_divider_sel_r)),
    .en(output_enable_r),
    .clkOut(foutInt)
  );

  // read mux
  logic [31:0] rdata;
  logic hit;
  always_comb begin
    rdata = 32'h00000000;
    hit = 1'b1;
    if (apbReq.paddr == OFS_PROTECT) begin
      rdata = {31'h0, unlocked_r};
    end else if (apbReq.paddr == OFS_SYSTEM_CLOCK) begin
      rdata = {16'h0, wakeEn_r, 1'b0, wakeDiv_r, 2'b00, wakeSrc_r, 2'b00, sysDiv_r, 2'b00, sysSrc_r};
    end else if (apbReq.paddr == OFS_OSCCTL) begin
      rdata = {20'h0, sleepStop_r, 4'h0, srcEn_r};
    end else if (apbReq.paddr == OFS_TRIM) begin
      rdata = {27'h0, trimStart_r, 4'h0};
    end else if (apbReq.paddr == OFS_INTFLAG) begin
      rdata = {27'h0, flags_r[2], 1'b0, flags_r[1], 1'b0, flags_r[0]};
    end else if (apbReq.paddr == OFS_INTEN) begin
      rdata = {27'h0, irqEn_r[2], 1'b0, irqEn_r[1], 1'b0, irqEn_r[0]};
    end else if (apbReq.paddr == OFS_FOUT) begin
      rdata = {25'h0, output_divider_sel_r, output_source_sel_r, 1'b0, output_enable_r};
    end else if (apbReq.paddr == OFS_HSADJ) begin
      rdata = {26'h0, hsAdj_r};
    end else if (apbReq.paddr == OFS_HSWAIT) begin
      rdata = {29'h0, hsWait_r};
    end else if (apbReq.paddr == OFS_MODE) begin
      rdata = {26'h0, actDiv_r, actSrc_r, cpuMode};
    end else begin
      hit = 1'b0;
    end
  end

  // outputs, all registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      apbRsp <= '0;
      mode_r <= MODE_RUN;
      sourceRun <= RST_ENABLES;
      rtcLowpowerInput <= 1'b0;
      systemClock <= 1'b0;
      clockOutputPin <= 1'b0;
      highspeedFineAdjust <= RST_HSADJ;
      highspeedSettleTime <= RST_HSWAIT;
      trimActive <= 1'b0;
      clkIrq <= 1'b0;
      cpuStop <= 1'b0;
      cpuMode <= 2'h0;
    end else begin
      // one wait state: answer is raised in the second access cycle, held for one
      apbRsp.pready <= accessPh && !apbRsp.pready;
      apbRsp.pslverr <= accessPh && !apbRsp.pready && !hit;
      if (accessPh && !apbRsp.pready && !apbReq.pwrite) begin
        apbRsp.prdata <= rdata;
      end
      mode_r <= mode_nxt;
      sourceRun <= runNow;
      rtcLowpowerInput <= runNow[SRC_LOWPOWER];
      systemClock <= sysClkInt;
      clockOutputPin <= foutInt && output_enable_r;
      highspeedFineAdjust <= hsAdj_r;
      highspeedSettleTime <= hsWait_r;
      trimActive <= trimStart_r;
      clkIrq <= |(flags_r & irqEn_r);
      cpuStop <= mode_nxt == MODE_HALT || mode_nxt == MODE_SLEEP;
      cpuMode <= 2'(mode_nxt);
    end
  end
  wire unusedSetup = setupPh;
endmodule

//--- dv/scg_osc_model.sv
// oscillator and clock input stand-ins that run only while requested
`timescale 1ns/1ps
module scg_osc_model (
  input wire logic clk, // block clock
  input wire logic resetn, // async reset, active low
  input wire logic [3:0] sourceRun, // run request per source
  output logic [3:0] oscClockPins // ext, high-speed, low-power, internal
);
  // half periods in block clocks, all above two so the synchroniser sees each level
  localparam logic [3:0] HALF [4] = '{4'h4, 4'hA, 4'h3, 4'h5};
  logic [3:0] cnt_r [4];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        cnt_r[i] <= 4'h0;
        oscClockPins[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!sourceRun[i]) begin
          // a stopped source stands low, it does not keep its last level
          cnt_r[i] <= 4'h0;
          oscClockPins[i] <= 1'b0;
        end else if (cnt_r[i] == HALF[i] - 4'h1) begin
          cnt_r[i] <= 4'h0;
          oscClockPins[i] <= ~oscClockPins[i];
        end else begin
          cnt_r[i] <= cnt_r[i] + 4'h1;
        end
      end
    end
  end
endmodule

//--- dv/scg_clock_gen_props.sv
// concurrent checks on the clock generator ports
`timescale 1ns/1ps
module scg_clock_gen_props (
  input wire logic clk, // block clock
  input wire logic resetn, // async reset, active low
  input wire scg_pkg::scg_apb_req_t apbReq, // apb request
  input wire scg_pkg::scg_apb_rsp_t apbRsp, // apb response
  input wire scg_pkg::scg_cpu_evt_t cpuEvt, // cpu events
  input wire logic [3:0] sourceRun, // run requests
  input wire logic rtcLowpowerInput, // rtc input gate
  input wire logic clockOutputPin, // output pin
  input wire logic cpuStop, // cpu held
  input wire logic [1:0] cpuMode // operating mode
);
  import scg_pkg::*;
  logic wrDone;
  logic [3:0] slpc_r;
  logic output_enable_r;
  logic [2:0] offHist_r;
  assign wrDone = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
  // mirrors of the sleep-stop bits and output enable, seen from the bus
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slpc_r <= 4'hF;
      output_enable_r <= 1'b0;
      offHist_r <= 3'h7;
    end else begin
      if (wrDone && apbReq.paddr == OFS_OSCCTL) slpc_r <= apbReq.pwdata[SLPC_LSB +: 4];
      if (wrDone && apbReq.paddr == OFS_FOUT) output_enable_r <= apbReq.pwdata[FOEN_BIT];
      offHist_r <= {offHist_r[1:0], !output_enable_r};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence apbAccess;
    apbReq.psel && apbReq.penable && !apbRsp.pready;
  endsequence
  sequence inSleep2;
    cpuMode == 2'h2 ##1 cpuMode == 2'h2;
  endsequence
  apb_one_wait_a: assert property (apbAccess |=> apbRsp.pready) else $error("pready not one cycle after access");
  pready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready) else $error("pready held two cycles");
  halt_enter_a: assert property (cpuMode == 2'h0 && cpuEvt.haltExec && !cpuEvt.debugIrq |=>
    cpuMode == 2'h1 && cpuStop) else $error("halt not entered");
  halt_clocks_a: assert property (cpuMode == 2'h1 ##1 cpuMode == 2'h1 |-> $stable(sourceRun))
    else $error("sources changed in halt");
  sleep_enter_a: assert property (cpuMode == 2'h0 && cpuEvt.sleepExec && !cpuEvt.debugIrq |=>
    cpuMode == 2'h2 && cpuStop) else $error("sleep not entered");
  sleep_stop_a: assert property (inSleep2 |-> (sourceRun & slpc_r) == 4'h0)
    else $error("stopped source still runs in sleep");
  rtc_gate_a: assert property (inSleep2 ##0 slpc_r[1] |-> !rtcLowpowerInput)
    else $error("rtc input passes in sleep");
  wake_run_a: assert property ((cpuMode == 2'h1 || cpuMode == 2'h2) && !cpuEvt.debugIrq &&
    (cpuEvt.periphIrq || cpuEvt.wdtNmi || cpuEvt.resetReq) |=> cpuMode == 2'h0 && !cpuStop)
    else $error("wake event did not return to run");
  debug_enter_a: assert property (cpuEvt.debugIrq |=> cpuMode == 2'h3) else $error("debug not entered");
  debug_exit_a: assert property (cpuMode == 2'h3 && cpuEvt.retdExec && !cpuEvt.debugIrq |=>
    cpuMode == 2'h0) else $error("debug not left");
  pin_quiet_a: assert property (&offHist_r |-> !clockOutputPin) else $error("output pin moves while off");
endmodule
bind scg_clock_gen scg_clock_gen_props chk (.clk(clk), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp),
  .cpuEvt(cpuEvt), .sourceRun(sourceRun), .rtcLowpowerInput(rtcLowpowerInput),
  .clockOutputPin(clockOutputPin), .cpuStop(cpuStop), .cpuMode(cpuMode));

//--- dv/scg_clock_gen_tb.sv
// self-checking bench for the system clock generator
`timescale 1ns/1ps
module scg_clock_gen_tb;
  import scg_pkg::*;
  localparam int TRIM_N = 2;
  logic clk, resetn, rtcLowpowerInput, systemClock, clockOutputPin, trimActive, clkIrq, cpuStop, err;
  scg_apb_req_t apbReq;
  scg_apb_rsp_t apbRsp;
  scg_cpu_evt_t cpuEvt;
  logic [3:0] oscClockPins, sourceRun;
  logic [5:0] highspeedFineAdjust;
  logic [2:0] highspeedSettleTime;
  logic [1:0] cpuMode;
  logic [31:0] rd;
  int n_fail, total_checks, cycles, hi, hiSys;
  scg_clock_gen #(.TRIM_EDGES(TRIM_N)) uut (.clk(clk), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp),
    .oscClockPins(oscClockPins), .cpuEvt(cpuEvt), .sourceRun(sourceRun), .rtcLowpowerInput(rtcLowpowerInput),
    .systemClock(systemClock), .clockOutputPin(clockOutputPin), .highspeedFineAdjust(highspeedFineAdjust),
    .highspeedSettleTime(highspeedSettleTime), .trimActive(trimActive), .clkIrq(clkIrq), .cpuStop(cpuStop),
    .cpuMode(cpuMode));
  scg_osc_model osc (.clk(clk), .resetn(resetn), .sourceRun(sourceRun), .oscClockPins(oscClockPins));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 50);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    if (n == 50) check(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic pollChk(input logic [7:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd !== exp && n < 300);
    check(rd, exp);
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    cpuEvt <= e;
    @(posedge clk);
    cpuEvt <= '0;
    repeat (2) @(posedge clk);
  endtask
  task automatic countHigh();
    hi = 0;
    hiSys = 0;
    repeat (60) begin
      @(posedge clk);
      if (clockOutputPin === 1'b1) hi++;
      if (systemClock === 1'b1) hiSys++;
    end
  endtask
  task automatic t_reset();
    check(32'(sourceRun), 32'h1);
    check(32'(highspeedSettleTime), 32'h6);
    rdChk(OFS_SYSTEM_CLOCK, 32'h0);
    rdChk(OFS_OSCCTL, 32'h0F01);
    rdChk(OFS_MODE, 32'h0);
    rdChk(OFS_INTFLAG, 32'h0);
    rdChk(8'h40, 32'h0);
    check(32'(err), 32'h1);
    $display("test reset done");
  endtask
  task automatic t_protect();
    wr(OFS_SYSTEM_CLOCK, 32'hB312);
    rdChk(OFS_SYSTEM_CLOCK, 32'h0);
    wr(OFS_PROTECT, 32'h0096);
    rdChk(OFS_PROTECT, 32'h1);
    wr(OFS_SYSTEM_CLOCK, 32'hA210);
    rdChk(OFS_SYSTEM_CLOCK, 32'hA210);
    pollChk(OFS_MODE, 32'h10);
    wr(OFS_PROTECT, 32'h0097);
    wr(OFS_SYSTEM_CLOCK, 32'h0);
    rdChk(OFS_SYSTEM_CLOCK, 32'hA210);
    $display("test protect done");
  endtask
  task automatic t_highspeed();
    wr(OFS_INTFLAG, 32'h15);
    wr(OFS_PROTECT, 32'h0096);
    wr(OFS_HSADJ, 32'h2A);
    wr(OFS_HSWAIT, 32'h0);
    wr(OFS_OSCCTL, 32'h0F05);
    repeat (2) @(posedge clk);
    check(32'(sourceRun), 32'h5);
    check(32'(highspeedFineAdjust), 32'h2A);
    check(32'(highspeedSettleTime), 32'h0);
    pollChk(OFS_INTFLAG, 32'h4);
    check(32'(clkIrq), 32'h0);
    wr(OFS_INTEN, 32'h4);
    repeat (2) @(posedge clk);
    check(32'(clkIrq), 32'h1);
    wr(OFS_INTFLAG, 32'h4);
    repeat (2) @(posedge clk);
    check(32'(clkIrq), 32'h0);
    $display("test highspeed done");
  endtask
  task automatic t_trim();
    wr(OFS_SYSTEM_CLOCK, 32'h0002);
    pollChk(OFS_MODE, 32'h08);
    wr(OFS_OSCCTL, 32'h0F06);
    wr(OFS_OSCCTL, 32'h0F07);
    pollChk(OFS_INTFLAG, 32'h1);
    wr(OFS_INTFLAG, 32'h1);
    wr(OFS_INTEN, 32'h10);
    wr(OFS_TRIM, 32'h10);
    rdChk(OFS_TRIM, 32'h10);
    check(32'(trimActive), 32'h1);
    pollChk(OFS_TRIM, 32'h0);
    rdChk(OFS_INTFLAG, 32'h10);
    check(32'(clkIrq), 32'h1);
    wr(OFS_INTFLAG, 32'h10);
    $display("test trim done");
  endtask
  task automatic t_sleep();
    wr(OFS_OSCCTL, 32'h0B07);
    wr(OFS_SYSTEM_CLOCK, 32'h9202);
    check(32'(rtcLowpowerInput), 32'h1);
    pulse(7'h20);
    check(32'(cpuMode), 32'h2);
    check(32'(sourceRun), 32'h4);
    check(32'(rtcLowpowerInput), 32'h0);
    pulse(7'h08);
    check(32'(cpuMode), 32'h0);
    rdChk(OFS_SYSTEM_CLOCK, 32'h9212);
    rdChk(OFS_OSCCTL, 32'h0B04);
    $display("test sleep done");
  endtask
  task automatic t_modes();
    logic [6:0] wk [3] = '{7'h08, 7'h04, 7'h01};
    foreach (wk[i]) begin
      pulse(7'h40);
      check(32'(cpuMode), 32'h1);
      check(32'(sourceRun), 32'h4);
      pulse(wk[i]);
      check(32'(cpuMode), 32'h0);
    end
    pulse(7'h20);
    pulse(7'h02);
    check(32'(cpuMode), 32'h3);
    pulse(7'h10);
    check(32'(cpuMode), 32'h0);
    $display("test modes done");
  endtask
  task automatic t_fout();
    wr(OFS_FOUT, 32'h09);
    countHigh();
    check(32'(hi > 10), 32'h1);
    // system clock runs from the high-speed source halved, so it must toggle, neither stuck high nor low
    check(32'(hiSys > 10 && hiSys < 50), 32'h1);
    wr(OFS_FOUT, 32'h0);
    repeat (3) @(posedge clk);
    countHigh();
    check(32'(hi), 32'h0);
    $display("test fout done");
  endtask
  initial begin
    resetn = 1'b0;
    apbReq = '0;
    cpuEvt = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_protect();
    t_highspeed();
    t_trim();
    t_sleep();
    t_modes();
    t_fout();
    finish_test();
  end
  // ceiling well above the several hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
  end
endmodule
